// ==== rtl/mtimer_regs.sv ====
// Five-channel timer: flags, counters, compare registers, run control
module mtimer_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [4:0] capture_in,
   input wire logic [14:0] dtc_ack,
   input wire logic [14:0] dtc_transfer_irq_disable_select,
   input wire logic [15:0] dead_time,
   output logic [4:0] pin_a_out,
   output logic [5:0] motor_out
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] run_r;
   logic [7:0] sync_r;
   logic [7:0] oe_r;
   logic [7:0] outctl_r;
   logic [15:0] count_r [5];
   logic [15:0] gr_r [5][4];
   logic [2:0] flags_r [5];
   logic [2:0] flag_seen_r [5];
   logic [7:0] ioctl_r [5];
   logic [7:0] mode_r [5];
   logic [4:0] pin_r;
   logic [15:0] dead_cnt_r;
   logic rev_active_r;
   logic toggle_r;
   logic [5:0] motor_r;
   logic [15:0] rdata_r;
   logic [4:0] cap_s1_r;
   logic [4:0] cap_s2_r;
   logic [4:0] cap_d_r;
   logic [4:0] run_ch;
   logic [4:0] sync_ch;
   logic [4:0] cap_edge;
   logic [4:0] preset_hit;
   logic [4:0] clr_hit;
   logic [3:0] sub;
   logic [3:0] chsel;
   logic ch_space;
   logic sync_clear;
   logic pos_lvl;
   logic neg_lvl;
   logic [5:0] motor_raw;

   assign run_ch = {run_r[7], run_r[6], run_r[2:0]};
   assign sync_ch = {sync_r[7], sync_r[6], sync_r[2:0]};
   assign sub = addr[3:0];
   assign chsel = 4'((addr - mtimer_pkg::ADDR_CH_BASE) >> 4);
   assign ch_space = (addr >= mtimer_pkg::ADDR_CH_BASE) &&
                     (chsel < 4'(mtimer_pkg::NUM_CH));

   // ------------------------------------------------------------
   // Capture input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cap_s1_r <= '0;
         cap_s2_r <= '0;
         cap_d_r <= '0;
      end else begin
         cap_s1_r <= capture_in;
         cap_s2_r <= cap_s1_r;
         cap_d_r <= cap_s2_r;
      end
   end
   // Third flop only feeds the edge detector, never the first stage
   assign cap_edge = cap_s2_r & ~cap_d_r;

   // ------------------------------------------------------------
   // Global control registers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         run_r <= '0;
         sync_r <= '0;
         oe_r <= mtimer_pkg::OE_FIXED_ONES;
         outctl_r <= '0;
      end else if (wr) begin
         if (addr == mtimer_pkg::ADDR_RUN)
            run_r <= wdata[7:0] & mtimer_pkg::RUN_MASK;
         if (addr == mtimer_pkg::ADDR_SYNC)
            sync_r <= wdata[7:0] & mtimer_pkg::RUN_MASK;
         if (addr == mtimer_pkg::ADDR_OE)
            oe_r <= (wdata[7:0] & mtimer_pkg::OE_MASK) |
                    mtimer_pkg::OE_FIXED_ONES;
         if (addr == mtimer_pkg::ADDR_OUTCTL)
            outctl_r <= wdata[7:0] & mtimer_pkg::OUTCTL_MASK;
      end
   end

   // ------------------------------------------------------------
   // Synchronous preset / clear detection
   // ------------------------------------------------------------
   // A clear on one synced channel: compare match on A in pwm mode
   always_comb begin
      sync_clear = 1'b0;
      for (int c = 0; c < 5; c++) begin
         clr_hit[c] = run_ch[c] && mode_r[c][mtimer_pkg::MODE_PWM] &&
                      count_r[c] == gr_r[c][0];
         if (clr_hit[c] && sync_ch[c])
            sync_clear = 1'b1;
         preset_hit[c] = wr && ch_space && sub == mtimer_pkg::SUB_COUNT &&
                         (chsel == 4'(c) ||
                          (sync_ch[c] && sync_ch[chsel[2:0]]));
      end
   end

   // ------------------------------------------------------------
   // Per-channel logic
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : ch
         localparam bit FOUR = (g == 0) || (g == 3) || (g == 4);
         localparam int NGR = FOUR ? 4 : 2;
         logic wr_ch;
         logic rd_ch;
         logic [2:0] set_ev;
         logic [2:0] wclr;
         logic [2:0] aclr;
         logic [3:0] match;
         assign wr_ch = wr && ch_space && chsel == 4'(g);
         assign rd_ch = rd && ch_space && chsel == 4'(g);

         always_comb begin
            for (int k = 0; k < 4; k++)
               match[k] = (k < NGR) && run_ch[g] &&
                          count_r[g] == gr_r[g][k] &&
                          !mode_r[g][mtimer_pkg::MODE_CAP_LSB + k];
            for (int k = 0; k < 3; k++)
               set_ev[k] = (k < NGR) && (match[k] ||
                  (cap_edge[g] && mode_r[g][mtimer_pkg::MODE_CAP_LSB + k]));
            if (!FOUR)
               set_ev[mtimer_pkg::FLAG_C] = 1'b0;
            for (int k = 0; k < 3; k++) begin
               wclr[k] = wr_ch && sub == mtimer_pkg::SUB_FLAGS &&
                         !wdata[k] && flag_seen_r[g][k];
               aclr[k] = dtc_ack[g*3+k] && !dtc_transfer_irq_disable_select[g*3+k];
            end
         end

         // Flags: set beats either clear
         // Read-before-clear guard: a stale write cannot erase a new event
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               flags_r[g] <= '0;
               flag_seen_r[g] <= '0;
            end else begin
               for (int k = 0; k < 3; k++) begin
                  if (set_ev[k])
                     flags_r[g][k] <= 1'b1;
                  else if (wclr[k] || aclr[k])
                     flags_r[g][k] <= 1'b0;
                  if (rd_ch && sub == mtimer_pkg::SUB_FLAGS &&
                      flags_r[g][k])
                     flag_seen_r[g][k] <= 1'b1;
                  else if (wclr[k] || !flags_r[g][k])
                     flag_seen_r[g][k] <= 1'b0;
               end
            end
         end

         // Counter
         always_ff @(posedge clock) begin
            if (!rst_n)
               count_r[g] <= mtimer_pkg::COUNT_RESET;
            else if (preset_hit[g])
               count_r[g] <= wdata;
            else if (clr_hit[g] || (sync_ch[g] && sync_clear))
               count_r[g] <= mtimer_pkg::COUNT_RESET;
            else if (run_ch[g])
               count_r[g] <= count_r[g] + 16'h0001;
         end

         // Compare registers with buffer transfer and capture
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               for (int k = 0; k < 4; k++)
                  gr_r[g][k] <= mtimer_pkg::GR_RESET;
            end else begin
               for (int k = 0; k < NGR; k++) begin
                  if (wr_ch && sub == mtimer_pkg::SUB_GRA + 4'(k))
                     gr_r[g][k] <= wdata;
                  else if (cap_edge[g] &&
                           mode_r[g][mtimer_pkg::MODE_CAP_LSB + k])
                     gr_r[g][k] <= count_r[g];
                  else if (FOUR && k < 2 && match[k] &&
                           mode_r[g][mtimer_pkg::MODE_PWM])
                     gr_r[g][k] <= gr_r[g][k | 2];
               end
            end
         end

         always_ff @(posedge clock) begin
            if (!rst_n) begin
               ioctl_r[g] <= '0;
               mode_r[g] <= '0;
            end else if (wr_ch) begin
               if (sub == mtimer_pkg::SUB_IOCTL)
                  ioctl_r[g] <= wdata[7:0];
               if (sub == mtimer_pkg::SUB_MODE)
                  mode_r[g] <= wdata[7:0];
            end
         end

         // Pin A: toggles on match A; when stopped, holds except that an io control write loads the initial level
         always_ff @(posedge clock) begin
            if (!rst_n)
               pin_r[g] <= 1'b0;
            else if (wr_ch && sub == mtimer_pkg::SUB_IOCTL && !run_ch[g])
               pin_r[g] <= wdata[mtimer_pkg::IO_INIT];
            else if (match[0])
               pin_r[g] <= ~pin_r[g];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Motor outputs (channels 3 and 4)
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dead_cnt_r <= '0;
         rev_active_r <= 1'b0;
      end else if (!(run_ch[3] || run_ch[4])) begin
         dead_cnt_r <= '0;
         rev_active_r <= 1'b0;
      end else if (dead_cnt_r >= dead_time) begin
         rev_active_r <= 1'b1;
      end else begin
         dead_cnt_r <= dead_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         toggle_r <= 1'b0;
      else if (!outctl_r[mtimer_pkg::TOGGLE_BIT])
         toggle_r <= 1'b0;
      else if (clr_hit[3])
         toggle_r <= ~toggle_r;
   end

   // Positive: {4B,4A,3B}; reverse: {4D,4C,3D}
   // Reverse legs stay at initial level until the dead time has run out, except 4C, which follows toggle_r,
   // so with toggle off a positive and a reverse switch never conduct together at start
   always_comb begin
      // Level 0 select: high initial, low active, high up-match
      pos_lvl = outctl_r[mtimer_pkg::PLS_BIT] ^
                (run_ch[3] ? ~pin_r[3] : 1'b1);
      neg_lvl = outctl_r[mtimer_pkg::RLS_BIT] ^
                (rev_active_r ? pin_r[4] : 1'b1);
      motor_raw = {neg_lvl, neg_lvl ^ toggle_r, neg_lvl,
                   pos_lvl, pos_lvl ^ toggle_r, pos_lvl};
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         motor_r <= '0;
      else
         motor_r <= motor_raw & oe_r[5:0];
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= '0;
         if (rd) begin
            if (addr == mtimer_pkg::ADDR_RUN)
               rdata_r <= {8'h00, run_r};
            else if (addr == mtimer_pkg::ADDR_SYNC)
               rdata_r <= {8'h00, sync_r};
            else if (addr == mtimer_pkg::ADDR_OE)
               rdata_r <= {8'h00, oe_r};
            else if (addr == mtimer_pkg::ADDR_OUTCTL)
               rdata_r <= {8'h00, outctl_r};
            else if (ch_space) begin
               unique case (sub)
                  mtimer_pkg::SUB_FLAGS:
                     rdata_r <= {13'h0000, flags_r[chsel[2:0]]};
                  mtimer_pkg::SUB_COUNT:
                     rdata_r <= count_r[chsel[2:0]];
                  mtimer_pkg::SUB_GRA:
                     rdata_r <= gr_r[chsel[2:0]][0];
                  mtimer_pkg::SUB_GRB:
                     rdata_r <= gr_r[chsel[2:0]][1];
                  mtimer_pkg::SUB_GRC:
                     rdata_r <= (chsel == 4'h1 || chsel == 4'h2) ?
                                16'h0000 : gr_r[chsel[2:0]][2];
                  mtimer_pkg::SUB_GRD:
                     rdata_r <= (chsel == 4'h1 || chsel == 4'h2) ?
                                16'h0000 : gr_r[chsel[2:0]][3];
                  mtimer_pkg::SUB_IOCTL:
                     rdata_r <= {8'h00, ioctl_r[chsel[2:0]]};
                  mtimer_pkg::SUB_MODE:
                     rdata_r <= {8'h00, mode_r[chsel[2:0]]};
                  default:
                     rdata_r <= '0;
               endcase
            end
         end
      end
   end

   assign rdata = rdata_r;
   assign pin_a_out = pin_r;
   assign motor_out = motor_r;
endmodule

// ==== rtl/mtimer_pkg.sv ====
// Constants for the five-channel timer register block
package mtimer_pkg;
   // ------------------------------------------------------------
   // Register map (word indices on the plain register port)
   // ------------------------------------------------------------
   localparam int unsigned NUM_CH = 5;
   localparam logic [7:0] ADDR_RUN = 8'h00;
   localparam logic [7:0] ADDR_SYNC = 8'h01;
   localparam logic [7:0] ADDR_OE = 8'h02;
   localparam logic [7:0] ADDR_OUTCTL = 8'h03;
   // Per channel block: base + ch * stride
   localparam logic [7:0] ADDR_CH_BASE = 8'h10;
   localparam logic [7:0] CH_STRIDE = 8'h10;
   localparam logic [3:0] SUB_FLAGS = 4'h0;
   localparam logic [3:0] SUB_COUNT = 4'h1;
   localparam logic [3:0] SUB_GRA = 4'h2;
   localparam logic [3:0] SUB_GRB = 4'h3;
   localparam logic [3:0] SUB_GRC = 4'h4;
   localparam logic [3:0] SUB_GRD = 4'h5;
   localparam logic [3:0] SUB_IOCTL = 4'h6;
   localparam logic [3:0] SUB_MODE = 4'h7;
   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] GR_RESET = 16'hffff;
   localparam logic [7:0] RUN_MASK = 8'hc7;
   localparam logic [7:0] OE_FIXED_ONES = 8'hc0;
   localparam logic [7:0] OE_MASK = 8'h3f;
   localparam logic [7:0] OUTCTL_MASK = 8'h43;
   localparam int unsigned FLAG_A = 0;
   localparam int unsigned FLAG_B = 1;
   localparam int unsigned FLAG_C = 2;
   localparam int unsigned TOGGLE_BIT = 6;
   localparam int unsigned RLS_BIT = 1;
   localparam int unsigned PLS_BIT = 0;
   // Mode register: bit0 pwm mode, bits 4:1 capture select for a..d
   localparam int unsigned MODE_PWM = 0;
   localparam int unsigned MODE_CAP_LSB = 1;
   // Io control register: bit0 initial pin level
   localparam int unsigned IO_INIT = 0;
   localparam logic [15:0] DEAD_DEFAULT = 16'h0004;
endpackage

// ==== verif/mtimer_regs_monitor.sv ====
// Assertion checker for the timer register block
module mtimer_regs_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic [4:0] pin_a_out,
   input wire logic [5:0] motor_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------
   // Shadow of software writes
   // ------------------------------------------------
   logic [5:0] oe_r;
   logic [5:0] oe_d_r;
   logic run0_r;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         oe_r <= 6'h00;
         oe_d_r <= 6'h00;
         run0_r <= 1'b0;
      end else begin
         oe_d_r <= oe_r;
         if (wr && addr == mtimer_pkg::ADDR_OE) begin
            oe_r <= wdata[5:0];
         end
         if (wr && addr == mtimer_pkg::ADDR_RUN) begin
            run0_r <= wdata[0];
         end
      end
   end
   sequence s_rd(logic [7:0] a);
      rd && addr == a;
   endsequence
   sequence s_io_wr;
      wr && addr == 8'h16;
   endsequence
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   a_idle_zero: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_run_resv: assert property (
      s_rd(mtimer_pkg::ADDR_RUN) |=> (rdata & 16'hff38) == 16'h0000)
      else $error("run register reserved bits not zero");
   a_sync_resv: assert property (
      s_rd(mtimer_pkg::ADDR_SYNC) |=> (rdata & 16'hff38) == 16'h0000)
      else $error("sync register reserved bits not zero");
   a_oe_ones: assert property (
      s_rd(mtimer_pkg::ADDR_OE) |=> rdata[15:6] == 10'h003)
      else $error("enable register fixed bits wrong");
   a_outctl_resv: assert property (
      s_rd(mtimer_pkg::ADDR_OUTCTL) |=> (rdata & 16'hffbc) == 16'h0000)
      else $error("output control reserved bits not zero");
   a_flag_c_none: assert property (
      rd && addr[3:0] == 4'h0 && addr[7:5] == 3'h1 |=> !rdata[2])
      else $error("flag c set in two-register channel");
   a_cd_absent: assert property (
      rd && addr[7:5] == 3'h1 && addr[3:1] == 3'h2 |=> rdata == 16'h0)
      else $error("missing compare register reads nonzero");
   a_oe_gate: assert property (
      (motor_out & ~oe_r & ~oe_d_r) == 6'h00)
      else $error("motor pin driven while disabled");
   a_stop_hold: assert property (
      !run0_r && !$past(run0_r) && !(wr && addr == 8'h16)
      |=> $stable(pin_a_out[0]))
      else $error("stopped channel pin changed");
   a_io_init: assert property (
      s_io_wr ##0 !run0_r |=> pin_a_out[0] == $past(wdata[0]))
      else $error("pin not at initial level after io write");
endmodule

bind mtimer_regs mtimer_regs_monitor mtimer_regs_monitor_i (
   .clock(clock),
   .rst_n(rst_n),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .pin_a_out(pin_a_out),
   .motor_out(motor_out)
);

// ==== verif/pin_load_model.sv ====
// Far-side model: capture source and load on the timer pins
module pin_load_model (
   input wire logic clock,
   input wire logic [4:0] pin_a_out,
   input wire logic [5:0] motor_out,
   output logic [4:0] capture_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      capture_in = 5'h00;
   end
   // Held several cycles so the two-flop sync sees the edge
   task automatic pulse(input int ch, input int slow);
      @(posedge clock);
      capture_in[ch] <= 1'b1;
      repeat (4 + slow) @(posedge clock);
      capture_in[ch] <= 1'b0;
   endtask
endmodule

// ==== verif/mtimer_regs_tb.sv ====
// Self-checking bench for the timer register block
module mtimer_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock;
   logic rst_n;
   logic [7:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic [4:0] capture_in;
   logic [14:0] dtc_ack;
   logic [14:0] dtc_transfer_irq_disable_select;
   logic [15:0] dead_time;
   logic [4:0] pin_a_out;
   logic [5:0] motor_out;
   logic [15:0] v;
   int miscompares = 0;
   int cmp_count = 0;
   mtimer_regs mtimer_regs_i (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .capture_in(capture_in), .dtc_ack(dtc_ack), .dtc_transfer_irq_disable_select(dtc_transfer_irq_disable_select),
      .dead_time(dead_time), .pin_a_out(pin_a_out), .motor_out(motor_out));
   pin_load_model pin_load_model_i (.clock(clock), .pin_a_out(pin_a_out),
      .motor_out(motor_out), .capture_in(capture_in));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Whole 16-bit words only
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      // Data stand in the cycle after the strobe edge
      @(posedge clock);
      d = rdata;
   endtask
   task automatic ck_rd(input logic [7:0] a, input logic [15:0] e);
      rd_reg(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask
   task automatic hit_a();
      wr_reg(8'h11, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0001);
      repeat (12) @(posedge clock);
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0000);
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset_values();
      ck_rd(mtimer_pkg::ADDR_RUN, 16'h0000);
      ck_rd(mtimer_pkg::ADDR_SYNC, 16'h0000);
      ck_rd(mtimer_pkg::ADDR_OE, 16'h00c0);
      ck_rd(mtimer_pkg::ADDR_OUTCTL, 16'h0000);
      ck_rd(8'h04, 16'h0000);
      for (int c = 0; c < 5; c++) begin
         ck_rd(8'(16 * c + 17), 16'h0000);
         for (int g = 2; g < 6; g++) begin
            v = ((c == 1 || c == 2) && g > 3) ? 16'h0 : 16'hffff;
            ck_rd(8'(16 * c + 16 + g), v);
         end
      end
   endtask
   task automatic t_masks();
      wr_reg(mtimer_pkg::ADDR_RUN, 16'hffff);
      ck_rd(mtimer_pkg::ADDR_RUN, 16'h00c7);
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_SYNC, 16'hffff);
      ck_rd(mtimer_pkg::ADDR_SYNC, 16'h00c7);
      wr_reg(mtimer_pkg::ADDR_OE, 16'hffff);
      ck_rd(mtimer_pkg::ADDR_OE, 16'h00ff);
      wr_reg(mtimer_pkg::ADDR_OUTCTL, 16'hffff);
      ck_rd(mtimer_pkg::ADDR_OUTCTL, 16'h0043);
      wr_reg(mtimer_pkg::ADDR_OUTCTL, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_OE, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_SYNC, 16'h0000);
      repeat (2) @(posedge clock);
      chk("motor pins", 16'h0, {10'h0, motor_out});
   endtask
   task automatic t_run_sync();
      hit_a();
      rd_reg(8'h11, v);
      chk("count moved", 16'h1, {15'h0, v != 16'h0});
      ck_rd(8'h11, v);
      wr_reg(8'h31, 16'h0055);
      wr_reg(mtimer_pkg::ADDR_SYNC, 16'h0003);
      wr_reg(8'h11, 16'h1234);
      ck_rd(8'h21, 16'h1234);
      ck_rd(8'h31, 16'h0055);
      wr_reg(mtimer_pkg::ADDR_SYNC, 16'h0000);
   endtask
   task automatic t_flags();
      wr_reg(8'h12, 16'h0005);
      wr_reg(8'h17, 16'h0000);
      hit_a();
      ck_rd(8'h10, 16'h0001);
      wr_reg(8'h10, 16'hffff);
      ck_rd(8'h10, 16'h0001);
      wr_reg(8'h10, 16'h0000);
      ck_rd(8'h10, 16'h0000);
      hit_a();
      wr_reg(8'h10, 16'h0000);
      ck_rd(8'h10, 16'h0001);
      dtc_transfer_irq_disable_select <= 15'h0001;
      dtc_ack <= 15'h0001;
      @(posedge clock);
      dtc_ack <= 15'h0000;
      ck_rd(8'h10, 16'h0001);
      dtc_transfer_irq_disable_select <= 15'h0000;
      dtc_ack <= 15'h0001;
      @(posedge clock);
      dtc_ack <= 15'h0000;
      ck_rd(8'h10, 16'h0000);
   endtask
   task automatic t_capture();
      for (int c = 0; c < 2; c++) begin
         wr_reg(8'(16 * c + 23), 16'h0008);
         wr_reg(mtimer_pkg::ADDR_RUN, 16'h0003);
         pin_load_model_i.pulse(c, 3 * c);
         repeat (4) @(posedge clock);
         wr_reg(mtimer_pkg::ADDR_RUN, 16'h0000);
         rd_reg(8'(16 * c + 16), v);
         chk("flag c", c == 0 ? 16'h4 : 16'h0, v & 16'h4);
         wr_reg(8'(16 * c + 23), 16'h0000);
      end
      rd_reg(8'h14, v);
      chk("captured", 16'h1, {15'h0, v != 16'hffff});
   endtask
   task automatic t_io();
      wr_reg(8'h16, 16'h0001);
      @(posedge clock);
      chk("pin a", 16'h1, {15'h0, pin_a_out[0]});
      wr_reg(8'h16, 16'h0000);
      @(posedge clock);
      chk("pin a", 16'h0, {15'h0, pin_a_out[0]});
   endtask
   task automatic t_pwm_sync();
      wr_reg(mtimer_pkg::ADDR_SYNC, 16'h0003);
      wr_reg(8'h11, 16'h0000);
      wr_reg(8'h12, 16'h0003);
      wr_reg(8'h14, 16'h0006);
      wr_reg(8'h17, 16'h0001);
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0003);
      repeat (20) @(posedge clock);
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0000);
      ck_rd(8'h12, 16'h0006);
      rd_reg(8'h11, v);
      chk("period clear", 16'h1, {15'h0, v < 16'h0007});
      ck_rd(8'h21, v);
      wr_reg(8'h17, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_SYNC, 16'h0000);
   endtask
   task automatic t_motor();
      wr_reg(mtimer_pkg::ADDR_OE, 16'h003f);
      wr_reg(8'h46, 16'h0000);
      wr_reg(8'h56, 16'h0000);
      repeat (2) @(posedge clock);
      chk("motor pins", 16'h003f, {10'h0, motor_out});
      wr_reg(mtimer_pkg::ADDR_OUTCTL, 16'h0003);
      repeat (2) @(posedge clock);
      chk("motor pins", 16'h0000, {10'h0, motor_out});
      wr_reg(mtimer_pkg::ADDR_OUTCTL, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0080);
      repeat (2) @(posedge clock);
      chk("motor pins", 16'h003f, {10'h0, motor_out});
      repeat (8) @(posedge clock);
      chk("motor pins", 16'h0007, {10'h0, motor_out});
      wr_reg(mtimer_pkg::ADDR_RUN, 16'h0000);
      wr_reg(mtimer_pkg::ADDR_OE, 16'h0000);
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      miscompares++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      dtc_ack = 15'h0000;
      dtc_transfer_irq_disable_select = 15'h0000;
      dead_time = mtimer_pkg::DEAD_DEFAULT;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      t_reset_values();
      t_masks();
      t_run_sync();
      t_flags();
      t_capture();
      t_pwm_sync();
      t_motor();
      t_io();
      results();
   end
endmodule
